// [core/rcrs_regs.svh]
// Register offsets, field positions, reset values and timing counts of the
// real-time counter register set.
// Assumes it is included by bare name; it holds definitions only.
`ifndef RCRS_REGS_SVH
`define RCRS_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RCRS_OFS_CTRL    4'h0
`define RCRS_OFS_STATUS  4'h1
`define RCRS_OFS_IRQEN   4'h2
`define RCRS_OFS_IRQPEND 4'h3
`define RCRS_OFS_STAGE   4'h4
`define RCRS_OFS_HALT    4'h5
`define RCRS_OFS_TRIM    4'h6
`define RCRS_OFS_SRC     4'h7
`define RCRS_OFS_CNT_L   4'h8
`define RCRS_OFS_CNT_H   4'h9
`define RCRS_OFS_PER_L   4'ha
`define RCRS_OFS_PER_H   4'hb
`define RCRS_OFS_CMP_L   4'hc
`define RCRS_OFS_CMP_H   4'hd

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RCRS_BIT_WRAP      0
`define RCRS_BIT_MATCH     1
`define RCRS_CH_CTRL       0
`define RCRS_CH_CNT        1
`define RCRS_CH_PER        2
`define RCRS_CH_CMP        3
`define RCRS_CTRL_EN       0
`define RCRS_CTRL_CORR     2
`define RCRS_CTRL_PRE_LSB  3
`define RCRS_CTRL_PRE_MSB  6
`define RCRS_TRIM_SIGN     7

// ----------------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------------
`define RCRS_RST_BYTE    8'h00
`define RCRS_RST_CNT     16'h0000
`define RCRS_RST_PER     16'hffff
`define RCRS_RST_CMP     16'h0000
`define RCRS_SYNC_TICKS  2'h2
`define RCRS_SLOW_DIV    5'h1f
`define RCRS_CORR_WINDOW 1000000

`endif

// [core/rcrs_pkg.sv]
// Types shared by the real-time counter register set.
// Assumes rcrs_regs.svh is reachable on the include path.
package rcrs_pkg;

	// ------------------------------------------------------------------------
	// Register port and counter clock sources
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rcrs_bus_s;

	typedef enum logic [1:0] {
		RCRS_SRC_SLOW     = 2'h0,
		RCRS_SRC_SLOW_DIV = 2'h1,
		RCRS_SRC_CRYSTAL  = 2'h2,
		RCRS_SRC_EXT      = 2'h3
	} rcrs_src_e;

	// ------------------------------------------------------------------------
	// State pieces
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic        busy;
		logic [1:0]  left;
		logic [15:0] val;
	} rcrs_sync_s;

	typedef struct packed {
		logic [2:0] sh;
		logic       lvl;
	} rcrs_pin_s;

	typedef struct packed {
		rcrs_pin_s  [2:0] pins;
		logic [4:0]       slow_div;
		logic [7:0]       ctrl;
		logic [7:0]       ctrl_eff;
		logic [1:0]       irq_en;
		logic [1:0]       pend;
		logic [7:0]       stage;
		logic             run_halted;
		logic [7:0]       trim;
		rcrs_src_e        src;
		logic [15:0]      count;
		logic [15:0]      per_w;
		logic [15:0]      per_eff;
		logic [15:0]      cmp_w;
		logic [15:0]      cmp_eff;
		rcrs_sync_s [3:0] sync;
		logic [15:0]      presc;
		logic [19:0]      ppm;
		logic [7:0]       rdata;
		logic             irq_match;
		logic             irq_wrap;
	} rcrs_state_s;

endpackage : rcrs_pkg

// [core/rcrs_core.sv]
// Register set and counting logic of a 16-bit real-time counter.
// Assumes a single 50 MHz clock, a synchronous active-high reset, and that
// the counter clock sources arrive as slow asynchronous pins.
//
// How it works
// [RULE_01] Busy bits 3..0 flag compare, period, count, control values in transit.
// [RULE_02] Enable bit 1 gates the compare match request.
// [RULE_03] Enable bit 0 gates the wrap request.
// [RULE_04] Pending bit 1 sets when the count equals the match value.
// [RULE_05] At the limit the count wraps to zero and pending bit 0 sets.
// [RULE_06] Writing one clears a pending bit; writing zero leaves it.
// [RULE_07] One shared byte stages the other half of every 16-bit access.
// [RULE_08] Halted without run-while-halted, the counter freezes and ignores ticks.
// [RULE_09] Trim bit 7 picks slower (0) or faster (1) correction.
// [RULE_10] Software must use at least divide-by-two with faster correction.
// [RULE_11] Trim bits 6..0 give correction clocks per million counter clocks.
// [RULE_12] Source select picks slow oscillator, its divided form, crystal, pin.
// [RULE_13] Count resets to zero; low byte at base, high byte at base+1.
// [RULE_14] A count write lands two counter clocks later; busy shows it.
// [RULE_15] Limit resets to all ones; low byte at base, high byte at base+1.
// [RULE_16] A limit write lands two counter clocks later; busy shows it.
// [RULE_17] Prescaler field divides the counter clock by two to its value.
// [RULE_18] Correction applies only while the correction enable is set.
// [RULE_19] A request stands while flag and enable are both set.
// [RULE_20] Enabled, the count steps once per prescaled tick; else it holds.
//
// The plain strobed port was chosen for this implementation.
`include "rcrs_regs.svh"

module rcrs_core #(
	parameter int CORR_WINDOW = `RCRS_CORR_WINDOW
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire rcrs_pkg::rcrs_bus_s bus,
	output logic [7:0]             rdata,
	input  wire logic              debug_halt,
	input  wire logic              osc_pin,
	input  wire logic              xtal_pin,
	input  wire logic              ext_pin,
	output logic                   irq_match,
	output logic                   irq_wrap
);
	import rcrs_pkg::*;

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------

	// Loads a channel with a value to carry into the counter domain.
	function automatic rcrs_sync_s start_sync(input logic [15:0] v);
		rcrs_sync_s s;
		s.busy = 1'b1;
		s.left = `RCRS_SYNC_TICKS;
		s.val  = v;
		return s;
	endfunction : start_sync

	// Highest prescaler position before a tick: two to the select, less one.
	function automatic logic [15:0] presc_term(input logic [3:0] sel);
		return 16'((17'h1 << sel) - 17'h1);
	endfunction : presc_term

	rcrs_state_s st_r;
	rcrs_state_s st_nxt;
	logic [2:0]  rise;
	logic        cclk;
	logic        run;
	logic        tick;
	logic        corr_on;
	logic [1:0]  inc;
	logic [16:0] psum;
	logic [15:0] term;
	logic [15:0] next_cnt;
	logic        wrap_hit;
	logic        match_hit;

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------

	// The pins are slow clocks from outside; each passes three flops and an
	// edge counts only once the second and third agree, so a glitch that lasts
	// a single system clock is never taken as a counter clock.
	always_comb begin
		st_nxt    = st_r;
		rise      = 3'h0;
		cclk      = 1'b0;
		run       = 1'b0;
		tick      = 1'b0;
		corr_on   = 1'b0;
		inc       = 2'h1;
		psum      = 17'h0;
		term      = 16'h0;
		next_cnt  = st_r.count;
		wrap_hit  = 1'b0;
		match_hit = 1'b0;

		for (int i = 0; i < 3; i++) begin
			st_nxt.pins[i].sh = {st_r.pins[i].sh[1:0],
				i == 0 ? osc_pin : (i == 1 ? xtal_pin : ext_pin)};
			if (st_r.pins[i].sh[1] == st_r.pins[i].sh[2]) begin
				st_nxt.pins[i].lvl = st_r.pins[i].sh[2];
				rise[i] = st_r.pins[i].sh[2] & ~st_r.pins[i].lvl;
			end
		end

		// The divided slow source gives one edge per 32 oscillator edges.
		if (rise[0]) begin
			st_nxt.slow_div = st_r.slow_div + 5'h1;
		end

		unique case (st_r.src) // see [RULE_12]
			RCRS_SRC_SLOW:     cclk = rise[0];
			RCRS_SRC_SLOW_DIV: cclk = rise[0] &&
				st_r.slow_div == `RCRS_SLOW_DIV;
			RCRS_SRC_CRYSTAL:  cclk = rise[1];
			RCRS_SRC_EXT:      cclk = rise[2];
		endcase

		// Halted without run-while-halted, the whole counter domain freezes, transfers too.
		run = cclk & ~(debug_halt & ~st_r.run_halted); // see [RULE_08]

		// Register port: reads answer in the next cycle only, zero otherwise.
		st_nxt.rdata = 8'h00;
		if (bus.rd) begin
			unique case (bus.addr)
				`RCRS_OFS_CTRL:    st_nxt.rdata = st_r.ctrl;
				`RCRS_OFS_STATUS:  st_nxt.rdata = {4'h0, // see [RULE_01]
					st_r.sync[3].busy, st_r.sync[2].busy,
					st_r.sync[1].busy, st_r.sync[0].busy};
				`RCRS_OFS_IRQEN:   st_nxt.rdata = {6'h0, st_r.irq_en};
				`RCRS_OFS_IRQPEND: st_nxt.rdata = {6'h0, st_r.pend};
				`RCRS_OFS_STAGE:   st_nxt.rdata = st_r.stage;
				`RCRS_OFS_HALT:    st_nxt.rdata = {7'h0, st_r.run_halted};
				`RCRS_OFS_TRIM:    st_nxt.rdata = st_r.trim;
				`RCRS_OFS_SRC:     st_nxt.rdata = {6'h0, st_r.src};
				`RCRS_OFS_CNT_L: begin // see [RULE_07] see [RULE_13]
					st_nxt.rdata = st_r.count[7:0];
					st_nxt.stage = st_r.count[15:8];
				end
				`RCRS_OFS_PER_L: begin // see [RULE_15]
					st_nxt.rdata = st_r.per_w[7:0];
					st_nxt.stage = st_r.per_w[15:8];
				end
				`RCRS_OFS_CMP_L: begin
					st_nxt.rdata = st_r.cmp_w[7:0];
					st_nxt.stage = st_r.cmp_w[15:8];
				end
				`RCRS_OFS_CNT_H,
				`RCRS_OFS_PER_H,
				`RCRS_OFS_CMP_H:   st_nxt.rdata = st_r.stage;
				default:           st_nxt.rdata = 8'h00;
			endcase
		end

		// A high-byte write joins the staged low byte, so the 16-bit value
		// moves in one piece and the counter never sees half an update.
		if (bus.wr) begin
			unique case (bus.addr)
				`RCRS_OFS_CTRL: begin
					st_nxt.ctrl = bus.wdata;
					st_nxt.sync[`RCRS_CH_CTRL] = start_sync({8'h0, bus.wdata});
				end
				`RCRS_OFS_IRQEN:   st_nxt.irq_en = bus.wdata[1:0];
				`RCRS_OFS_IRQPEND: begin
					st_nxt.pend = st_r.pend & ~bus.wdata[1:0]; // see [RULE_06]
				end
				`RCRS_OFS_STAGE:   st_nxt.stage = bus.wdata;
				`RCRS_OFS_HALT:    st_nxt.run_halted = bus.wdata[0];
				`RCRS_OFS_TRIM:    st_nxt.trim = bus.wdata;
				`RCRS_OFS_SRC:     st_nxt.src = rcrs_src_e'(bus.wdata[1:0]);
				`RCRS_OFS_CNT_L,
				`RCRS_OFS_PER_L,
				`RCRS_OFS_CMP_L:   st_nxt.stage = bus.wdata; // see [RULE_07]
				`RCRS_OFS_CNT_H: begin // see [RULE_14]
					st_nxt.sync[`RCRS_CH_CNT] =
						start_sync({bus.wdata, st_r.stage});
				end
				`RCRS_OFS_PER_H: begin // see [RULE_16]
					st_nxt.per_w = {bus.wdata, st_r.stage};
					st_nxt.sync[`RCRS_CH_PER] =
						start_sync({bus.wdata, st_r.stage});
				end
				`RCRS_OFS_CMP_H: begin
					st_nxt.cmp_w = {bus.wdata, st_r.stage};
					st_nxt.sync[`RCRS_CH_CMP] =
						start_sync({bus.wdata, st_r.stage});
				end
				default: begin
				end
			endcase
		end

		// Counter domain work happens only on a live counter clock edge.
		if (run) begin
			// Transfers: a value lands on the second edge after its write.
			// A write that comes while a transfer runs restarts it.
			for (int c = 0; c < 4; c++) begin
				// A channel restarted on this edge waits two further edges.
				if (st_r.sync[c].busy &&
					st_nxt.sync[c] == st_r.sync[c]) begin
					st_nxt.sync[c].left = st_nxt.sync[c].left - 2'h1;
					if (st_nxt.sync[c].left == 2'h0) begin
						st_nxt.sync[c].busy = 1'b0; // see [RULE_01]
					end
				end
			end

			// Correction spreads its clocks over the first slots of each
			// million-clock window; slots are cheap and need no divider.
			st_nxt.ppm = (st_r.ppm == 20'(CORR_WINDOW - 1)) ?
				20'h0 : st_r.ppm + 20'h1;
			corr_on = st_r.ctrl_eff[`RCRS_CTRL_CORR] && // see [RULE_18]
				{13'h0, st_r.trim[6:0]} > st_r.ppm; // see [RULE_11]
			if (corr_on) begin
				// Slower skips a step, faster takes two. see [RULE_09]
				inc = st_r.trim[`RCRS_TRIM_SIGN] ? 2'h2 : 2'h0;
			end

			// Faster correction relies on divide-by-two or more. see [RULE_10]
			term = presc_term(st_r.ctrl_eff[`RCRS_CTRL_PRE_MSB:
				`RCRS_CTRL_PRE_LSB]); // see [RULE_17]
			psum = {1'b0, st_r.presc} + {15'h0, inc};
			if (st_r.ctrl_eff[`RCRS_CTRL_EN]) begin // see [RULE_20]
				if (psum > {1'b0, term}) begin
					tick = 1'b1;
					st_nxt.presc = 16'(psum - {1'b0, term} - 17'h1);
				end else begin
					st_nxt.presc = psum[15:0];
				end
			end

			if (tick) begin
				wrap_hit = st_r.count == st_r.per_eff; // see [RULE_05]
				next_cnt = wrap_hit ? 16'h0 : st_r.count + 16'h1;
				match_hit = next_cnt == st_r.cmp_eff; // see [RULE_04]
				st_nxt.count = next_cnt;
			end

			// Landed values take over in the counter domain.
			if (st_r.sync[`RCRS_CH_CTRL].busy &&
				st_r.sync[`RCRS_CH_CTRL].left == 2'h1) begin
				st_nxt.ctrl_eff = st_r.sync[`RCRS_CH_CTRL].val[7:0];
			end
			if (st_r.sync[`RCRS_CH_CNT].busy &&
				st_r.sync[`RCRS_CH_CNT].left == 2'h1) begin
				st_nxt.count = st_r.sync[`RCRS_CH_CNT].val; // see [RULE_14]
			end
			if (st_r.sync[`RCRS_CH_PER].busy &&
				st_r.sync[`RCRS_CH_PER].left == 2'h1) begin
				st_nxt.per_eff = st_r.sync[`RCRS_CH_PER].val; // see [RULE_16]
			end
			if (st_r.sync[`RCRS_CH_CMP].busy &&
				st_r.sync[`RCRS_CH_CMP].left == 2'h1) begin
				st_nxt.cmp_eff = st_r.sync[`RCRS_CH_CMP].val;
			end
		end

		// Hardware sets come after the software clear so a set wins.
		if (wrap_hit) begin
			st_nxt.pend[`RCRS_BIT_WRAP] = 1'b1; // see [RULE_05]
		end
		if (match_hit) begin
			st_nxt.pend[`RCRS_BIT_MATCH] = 1'b1; // see [RULE_04]
		end

		// Requests follow flag and enable in the same cycle as the flag.
		st_nxt.irq_match = st_nxt.pend[`RCRS_BIT_MATCH] && // see [RULE_02]
			st_nxt.irq_en[`RCRS_BIT_MATCH]; // see [RULE_19]
		st_nxt.irq_wrap = st_nxt.pend[`RCRS_BIT_WRAP] && // see [RULE_03]
			st_nxt.irq_en[`RCRS_BIT_WRAP]; // see [RULE_19]
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------

	// Reset loads constants only; the pin shifters restart from low.
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r         <= '0;
			st_r.count   <= `RCRS_RST_CNT; // see [RULE_13]
			st_r.per_w   <= `RCRS_RST_PER; // see [RULE_15]
			st_r.per_eff <= `RCRS_RST_PER;
			st_r.cmp_w   <= `RCRS_RST_CMP;
			st_r.cmp_eff <= `RCRS_RST_CMP;
			st_r.stage   <= `RCRS_RST_BYTE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata     = st_r.rdata;
	assign irq_match = st_r.irq_match;
	assign irq_wrap  = st_r.irq_wrap;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_cnt_hi_write;
		bus.wr && bus.addr == `RCRS_OFS_CNT_H;
	endsequence

	sequence s_cnt_landing;
		run && st_r.sync[`RCRS_CH_CNT].busy &&
			st_r.sync[`RCRS_CH_CNT].left == 2'h1 && !bus.wr;
	endsequence

	property p_cnt_busy;
		s_cnt_hi_write |=> st_r.sync[`RCRS_CH_CNT].busy &&
			st_r.sync[`RCRS_CH_CNT].val == {$past(bus.wdata), $past(st_r.stage)};
	endproperty
	a_cnt_busy: assert property (p_cnt_busy) // see [RULE_01]
		else $error("count busy not raised by high byte write");

	property p_cnt_land;
		s_cnt_landing |=> !st_r.sync[`RCRS_CH_CNT].busy &&
			st_r.count == $past(st_r.sync[`RCRS_CH_CNT].val);
	endproperty
	a_cnt_land: assert property (p_cnt_land) // see [RULE_14]
		else $error("count write did not land on second counter edge");

	property p_wrap_flag;
		tick && st_r.count == st_r.per_eff && !st_r.sync[`RCRS_CH_CNT].busy
			|=> st_r.pend[`RCRS_BIT_WRAP] && st_r.count == 16'h0;
	endproperty
	a_wrap_flag: assert property (p_wrap_flag) // see [RULE_05]
		else $error("wrap at limit did not zero count and set flag");

	property p_match_flag;
		match_hit |=> st_r.pend[`RCRS_BIT_MATCH];
	endproperty
	a_match_flag: assert property (p_match_flag) // see [RULE_04]
		else $error("match flag not set on equal count");

	property p_w1c;
		bus.wr && bus.addr == `RCRS_OFS_IRQPEND && bus.wdata[0] && !wrap_hit
			|=> !st_r.pend[`RCRS_BIT_WRAP];
	endproperty
	a_w1c: assert property (p_w1c) // see [RULE_06]
		else $error("writing one did not clear wrap flag");

	property p_w0_keeps;
		bus.wr && bus.addr == `RCRS_OFS_IRQPEND && !bus.wdata[1] &&
			st_r.pend[`RCRS_BIT_MATCH] |=> st_r.pend[`RCRS_BIT_MATCH];
	endproperty
	a_w0_keeps: assert property (p_w0_keeps) // see [RULE_06]
		else $error("writing zero disturbed match flag");

	property p_irq_match;
		st_r.pend[`RCRS_BIT_MATCH] && st_r.irq_en[`RCRS_BIT_MATCH]
			|-> irq_match;
	endproperty
	a_irq_match: assert property (p_irq_match) // see [RULE_02]
		else $error("match request missing while flag and enable set");

	property p_irq_wrap;
		irq_wrap |-> st_r.pend[`RCRS_BIT_WRAP] && st_r.irq_en[`RCRS_BIT_WRAP];
	endproperty
	a_irq_wrap: assert property (p_irq_wrap) // see [RULE_03]
		else $error("wrap request without flag and enable");

	property p_stage_read;
		bus.rd && bus.addr == `RCRS_OFS_CNT_L
			|=> st_r.stage == $past(st_r.count[15:8]);
	endproperty
	a_stage_read: assert property (p_stage_read) // see [RULE_07]
		else $error("low byte read did not stage high byte");

	property p_halt_freeze;
		debug_halt && !st_r.run_halted |=> $stable(st_r.count);
	endproperty
	a_halt_freeze: assert property (p_halt_freeze) // see [RULE_08]
		else $error("count moved while halted");

	property p_hold_disabled;
		!st_r.ctrl_eff[`RCRS_CTRL_EN] && !st_r.sync[`RCRS_CH_CNT].busy
			|=> $stable(st_r.count);
	endproperty
	a_hold_disabled: assert property (p_hold_disabled) // see [RULE_20]
		else $error("count moved while disabled");

	property p_read_once;
		!bus.rd |=> rdata == 8'h00;
	endproperty
	a_read_once: assert property (p_read_once) // see [RULE_13]
		else $error("read data stood outside its cycle");

endmodule : rcrs_core

// [tb/rcrs_core_tb.sv]
// Self-checking testbench of the real-time counter register set.
// Assumes rcrs_pkg is compiled first and rcrs_regs.svh is on the include path.
`include "rcrs_regs.svh"

module rcrs_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rcrs_pkg::*;

	// ------------------------------------------------------------------------
	// Clock, reset, stimulus and counters
	// ------------------------------------------------------------------------
	logic        clk;
	logic        rst;
	rcrs_bus_s   bus;
	logic [7:0]  rdata;
	logic        debug_halt;
	logic        osc_pin;
	logic        xtal_pin;
	logic        ext_pin;
	logic        irq_match;
	logic        irq_wrap;
	int          bad_count;
	int          samples_checked;
	int          cycles = 0;
	logic [7:0]  rb;
	logic [15:0] r16;
	logic [15:0] base;
	logic [15:0] val;
	logic [7:0]  d;

	// A short correction window keeps any trim effect inside the run.
	rcrs_core #(.CORR_WINDOW(200)) u_rcrs_core (
		.clk       (clk),
		.rst       (rst),
		.bus       (bus),
		.rdata     (rdata),
		.debug_halt(debug_halt),
		.osc_pin   (osc_pin),
		.xtal_pin  (xtal_pin),
		.ext_pin   (ext_pin),
		.irq_match (irq_match),
		.irq_wrap  (irq_wrap)
	);

	// Free-running 50 MHz clock.
	always #10 clk = ~clk;

	// Cuts a hang short; the whole run needs under two thousand cycles.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count = bad_count + 1;
			final_report();
		end
	end

	// ------------------------------------------------------------------------
	// Bus, pin and compare tasks
	// ------------------------------------------------------------------------
	// Each access leaves an idle edge so no strobe is assigned twice at once.
	task automatic wr8(input logic [3:0] a, input logic [7:0] dat);
		bus.addr <= a;
		bus.wdata <= dat;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask : wr8

	// Read data stand only in the cycle after the strobe.
	task automatic rd8(input logic [3:0] a, output logic [7:0] q);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		q = rdata;
		@(posedge clk);
	endtask : rd8

	// Low byte first so the staging byte carries the low half.
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		wr8(a, v[7:0]);
		wr8(a + 4'h1, v[15:8]);
	endtask : wr16

	task automatic rd16(input logic [3:0] a, output logic [15:0] q);
		rd8(a, q[7:0]);
		rd8(a + 4'h1, q[15:8]);
	endtask : rd16

	// One rising edge per pulse on the pin that feeds source s.
	task automatic pulse(input int n, input logic [1:0] s);
		repeat (n) begin
			if (s == 2'h2) xtal_pin <= 1'b1;
			else if (s == 2'h3) ext_pin <= 1'b1;
			else osc_pin <= 1'b1;
			repeat (4) @(posedge clk);
			osc_pin <= 1'b0;
			xtal_pin <= 1'b0;
			ext_pin <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask : pulse

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk16

	task automatic chk_bit(input logic got, input logic exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_bit

	// Count after n ticks, wrapping to zero after the limit.
	function automatic logic [15:0] exp_count(input logic [15:0] c,
			input int n, input logic [15:0] lim);
		for (int i = 0; i < n; i++) begin
			c = (c == lim) ? 16'h0000 : c + 16'h0001;
		end
		return c;
	endfunction : exp_count

	// Prescaler ticks over n counter edges from window slot p, with k
	// correction slots of the given sign and a divide of two to sel.
	function automatic int exp_ticks(input int p, input int n, input int k,
			input logic sign, input int sel);
		int acc;
		int t;
		acc = 0;
		t = 0;
		for (int i = p; i < p + n; i++) begin
			acc = acc + ((i < k) ? (sign ? 2 : 0) : 1);
			if (acc >= (1 << sel)) begin
				acc = acc - (1 << sel);
				t = t + 1;
			end
		end
		return t;
	endfunction : exp_ticks

	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	localparam logic [3:0] OFS [7] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7,
		4'he};
	localparam logic [7:0] MSK [7] = '{8'h00, 8'h03, 8'hff, 8'h01, 8'hff,
		8'h03, 8'h00};

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		bus = '0;
		debug_halt = 1'b0;
		osc_pin = 1'b0;
		xtal_pin = 1'b0;
		ext_pin = 1'b0;
		bad_count = 0;
		samples_checked = 0;
		d = 8'($urandom(23812));
		repeat (5) @(posedge clk);
		rst <= 1'b0;

		// Registers 0 to 7, count and limit at reset value, halves read through staging.
		for (int i = 0; i < 8; i++) begin
			rd8(4'(i), rb);
			chk8(rb, 8'h00);
		end
		rd16(`RCRS_OFS_CNT_L, r16);
		chk16(r16, 16'h0000);
		rd16(`RCRS_OFS_PER_L, r16);
		chk16(r16, 16'hffff);
		$display("test reset_values done");

		// Random readback with field masks; status and reserved ignore writes.
		for (int i = 0; i < 7; i++) begin
			d = 8'($urandom());
			wr8(OFS[i], d);
			rd8(OFS[i], rb);
			chk8(rb, d & MSK[i]);
			wr8(OFS[i], 8'h00);
		end
		$display("test register_access done");

		// Three transfers in flight show as busy until two counter edges.
		wr8(`RCRS_OFS_SRC, 8'h02);
		val = 16'($urandom());
		wr16(`RCRS_OFS_CNT_L, val);
		rd8(`RCRS_OFS_STATUS, rb);
		chk8(rb, 8'h02);
		wr16(`RCRS_OFS_PER_L, 16'h1234);
		wr16(`RCRS_OFS_CMP_L, 16'h5678);
		rd8(`RCRS_OFS_STATUS, rb);
		chk8(rb, 8'h0e);
		pulse(1, 2'h2);
		rd8(`RCRS_OFS_STATUS, rb);
		chk8(rb, 8'h0e);
		pulse(1, 2'h2);
		rd8(`RCRS_OFS_STATUS, rb);
		chk8(rb, 8'h00);
		rd16(`RCRS_OFS_CNT_L, r16);
		chk16(r16, val);
		rd16(`RCRS_OFS_PER_L, r16);
		chk16(r16, 16'h1234);
		$display("test sync_busy done");

		// Limit 5, match 4, both requests enabled, counting from 3.
		wr16(`RCRS_OFS_CNT_L, 16'h0003);
		wr16(`RCRS_OFS_PER_L, 16'h0005);
		wr16(`RCRS_OFS_CMP_L, 16'h0004);
		wr8(`RCRS_OFS_IRQEN, 8'h03);
		wr8(`RCRS_OFS_CTRL, 8'h01);
		pulse(2, 2'h2);
		rd16(`RCRS_OFS_CNT_L, r16);
		chk16(r16, 16'h0003);
		pulse(1, 2'h2);
		rd8(`RCRS_OFS_IRQPEND, rb);
		chk8(rb, 8'h02);
		chk_bit(irq_match, 1'b1);
		chk_bit(irq_wrap, 1'b0);
		pulse(2, 2'h2);
		rd16(`RCRS_OFS_CNT_L, r16);
		chk16(r16, 16'h0000);
		rd8(`RCRS_OFS_IRQPEND, rb);
		chk8(rb, 8'h03);
		chk_bit(irq_wrap, 1'b1);
		wr8(`RCRS_OFS_IRQPEND, 8'h00);
		rd8(`RCRS_OFS_IRQPEND, rb);
		chk8(rb, 8'h03);
		wr8(`RCRS_OFS_IRQPEND, 8'h01);
		rd8(`RCRS_OFS_IRQPEND, rb);
		chk8(rb, 8'h02);
		chk_bit(irq_wrap, 1'b0);
		chk_bit(irq_match, 1'b1);
		wr8(`RCRS_OFS_IRQPEND, 8'h02);
		chk_bit(irq_match, 1'b0);
		wr8(`RCRS_OFS_IRQEN, 8'h01);
		pulse(4, 2'h2);
		rd8(`RCRS_OFS_IRQPEND, rb);
		chk8(rb, 8'h02);
		chk_bit(irq_match, 1'b0);
		wr8(`RCRS_OFS_IRQPEND, 8'h03);
		$display("test flags_and_requests done");

		// Halted in debug the count freezes unless run-while-halted is set.
		debug_halt <= 1'b1;
		pulse(3, 2'h2);
		rd16(`RCRS_OFS_CNT_L, r16);
		chk16(r16, 16'h0004);
		wr8(`RCRS_OFS_HALT, 8'h01);
		pulse(3, 2'h2);
		rd16(`RCRS_OFS_CNT_L, r16);
		chk16(r16, exp_count(16'h0004, 3, 16'h0005));
		debug_halt <= 1'b0;
		$display("test debug_halt done");

		// Divide by two: four counter edges give exactly two steps.
		wr8(`RCRS_OFS_CTRL, 8'h09);
		rd8(`RCRS_OFS_STATUS, rb);
		chk8(rb, 8'h01);
		pulse(2, 2'h2);
		rd16(`RCRS_OFS_CNT_L, base);
		pulse(4, 2'h2);
		rd16(`RCRS_OFS_CNT_L, r16);
		chk16(r16, exp_count(base, 2, 16'h0005));
		wr8(`RCRS_OFS_CTRL, 8'h08);
		pulse(2, 2'h2);
		rd16(`RCRS_OFS_CNT_L, base);
		pulse(4, 2'h2);
		rd16(`RCRS_OFS_CNT_L, r16);
		chk16(r16, base);
		wr8(`RCRS_OFS_CTRL, 8'h01);
		pulse(2, 2'h2);
		$display("test prescaler done");

		// Each source counts only its own pin; source 1 divides by 32.
		// Another pin is pulsed first and must leave the count alone.
		for (int s = 0; s < 4; s++) begin
			wr8(`RCRS_OFS_SRC, 8'(s));
			rd16(`RCRS_OFS_CNT_L, base);
			pulse(2, 2'(s + 2));
			pulse((s == 1) ? 64 : 2, 2'(s));
			rd16(`RCRS_OFS_CNT_L, r16);
			chk16(r16, exp_count(base, 2, 16'h0005));
		end
		$display("test clock_sources done");

		// A mid-run reset restarts the correction window, so its slots are
		// known; the control transfer spends slots 0 and 1 before counting.
		for (int sg = 0; sg < 2; sg++) begin
			rst <= 1'b1;
			repeat (2) @(posedge clk);
			rst <= 1'b0;
			rd16(`RCRS_OFS_CNT_L, r16);
			chk16(r16, 16'h0000);
			chk_bit(irq_wrap, 1'b0);
			wr8(`RCRS_OFS_TRIM, {sg[0], 7'h05});
			wr8(`RCRS_OFS_CTRL, 8'h0d);
			pulse(6, 2'h0);
			rd16(`RCRS_OFS_CNT_L, r16);
			val = 16'(exp_ticks(2, 4, 5, sg[0], 1));
			chk16(r16, val);
		end
		$display("test correction done");
		final_report();
	end

endmodule : rcrs_core_tb
